// ### hdl/ctu_edge_ctrl.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Two-bit range field, current control bits 1:0; code 01 is lowest
// - Six-bit trim field, bits 7:2; all-zero applies no adjustment
// - Trim signed: 100001 largest reduction, 011111 largest increase
// - Channel sources from edge low bits 3:2 and 6:5
// - Channel inputs respond to present level, not transitions
// - Polarity bits: channel 2 bit 7, channel 1 bit 4
// - Sequence enable: channel 2 accepted only after channel 1
// - Status bits 1:0 set by hardware on channel event
// - Reconfiguring to match present level sets status at once
// - Current source on only while exactly one status bit set
// - Software status writes gate current source like hardware sets
// - Flag set when current source turns on then off
// - Interrupt request only when flag and enable both set
// - Reset: negative polarities, sequencing disabled
// - Mode bit chooses measurement or delay; measurement default
// - Discharge output follows discharge bit; software times it
// - Delay mode routes pulse generation to comparator 2
// - Delay mode connects charged node to comparator 2 input 1
module ctu_edge_ctrl (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [3:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  input  wire logic                  edge_pin_one_i,
  input  wire logic                  edge_pin_two_i,
  input  wire logic                  timer_evt_i,
  input  wire logic                  compare_evt_i,
  output logic                       source_on_o,
  output logic      [1:0]            current_range_sel_o,
  output logic      [5:0]            current_trim_o,
  output logic                       discharge_o,
  output logic                       module_on_o,
  output logic                       delay_route_o,
  output logic                       irq_o
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Pins and the timer/compare sources come from outside this clock
  logic [3:0] raw_in;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] level_reg;

  assign raw_in = {edge_pin_one_i, edge_pin_two_i, timer_evt_i, compare_evt_i};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_level
      // A change counts once stages two and three agree
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          level_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          level_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  ctu_pkg::ctu_sources_t srcs;
  assign srcs = ctu_pkg::ctu_sources_t'(level_reg);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] cur_ctrl_reg;
  logic [7:0] edge_low_reg;
  logic [7:0] edge_high_reg;
  logic       flag_reg;
  logic       irq_en_reg;

  logic wr_cur;
  logic wr_low;
  logic wr_high;
  assign wr_cur  = wr_i && (addr_i == ctu_pkg::ADDR_CUR_CTRL);
  assign wr_low  = wr_i && (addr_i == ctu_pkg::ADDR_EDGE_LOW);
  assign wr_high = wr_i && (addr_i == ctu_pkg::ADDR_EDGE_HIGH);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ctrl_reg <= ctu_pkg::RST_CUR_CTRL;
    end else if (wr_cur) begin
      cur_ctrl_reg <= wdata_i;
    end
  end

  // Reset value zero gives no sequencing, closed edge inputs and module off
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_high_reg <= ctu_pkg::RST_EDGE_HIGH;
    end else if (wr_high) begin
      edge_high_reg <= wdata_i;
    end
  end

  // ------------------------------------------------------------
  // Edge channels
  // ------------------------------------------------------------
  function automatic logic pick(input ctu_pkg::ctu_sources_t s, input logic [1:0] sel);
    logic r;
    r = 1'b0;
    unique case (sel)
      ctu_pkg::SRC_PIN_ONE: r = s.pin_one;
      ctu_pkg::SRC_PIN_TWO: r = s.pin_two;
      ctu_pkg::SRC_TIMER:   r = s.timer;
      ctu_pkg::SRC_COMPARE: r = s.compare;
    endcase
    return r;
  endfunction : pick

  logic [1:0] chan1_source_sel;
  logic [1:0] chan2_source_sel;
  logic       chan1_polarity;
  logic       chan2_polarity;
  logic       sequence_enable;
  logic       edge_inputs_enable;
  logic       module_enable;
  logic       chan1_hit;
  logic       chan2_hit;
  logic       edges_open;

  assign chan1_source_sel   = edge_low_reg[ctu_pkg::SRC1_LSB +: 2];
  assign chan2_source_sel   = edge_low_reg[ctu_pkg::SRC2_LSB +: 2];
  assign chan1_polarity     = edge_low_reg[ctu_pkg::POL1_BIT];
  assign chan2_polarity     = edge_low_reg[ctu_pkg::POL2_BIT];
  assign sequence_enable    = edge_high_reg[ctu_pkg::SEQ_BIT];
  assign edge_inputs_enable = edge_high_reg[ctu_pkg::EDGE_INPUTS_ENABLE_BIT];
  assign module_enable      = edge_high_reg[ctu_pkg::MODEN_BIT];
  assign edges_open         = edge_inputs_enable && module_enable;

  // Level compare, no edge detect; config changes act at once
  assign chan1_hit = edges_open &&
                     (pick(srcs, chan1_source_sel) == chan1_polarity);
  assign chan2_hit = edges_open &&
                     (pick(srcs, chan2_source_sel) == chan2_polarity) &&
                     (!sequence_enable || edge_low_reg[ctu_pkg::STAT1_BIT]);

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_low_reg <= ctu_pkg::RST_EDGE_LOW;
    end else begin
      if (wr_low) begin
        edge_low_reg <= wdata_i;
      end
      if (chan1_hit) begin
        edge_low_reg[ctu_pkg::STAT1_BIT] <= 1'b1;
      end
      if (chan2_hit) begin
        edge_low_reg[ctu_pkg::STAT2_BIT] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Current source and flag
  // ------------------------------------------------------------
  logic src_on;
  assign src_on = edge_low_reg[ctu_pkg::STAT1_BIT] ^ edge_low_reg[ctu_pkg::STAT2_BIT];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      source_on_o <= 1'b0;
    end else begin
      source_on_o <= src_on;
    end
  end

  logic wr_flag;
  assign wr_flag = wr_i && (addr_i == ctu_pkg::ADDR_FLAGS3);

  // Off after on sets the flag; this set wins over a clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (source_on_o && !src_on) begin
      flag_reg <= 1'b1;
    end else if (wr_flag) begin
      flag_reg <= wdata_i[ctu_pkg::IRQ_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_reg <= 1'b0;
    end else if (wr_i && (addr_i == ctu_pkg::ADDR_ENABLES3)) begin
      irq_en_reg <= wdata_i[ctu_pkg::IRQ_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= flag_reg && irq_en_reg;
    end
  end

  // ------------------------------------------------------------
  // Analog control outputs
  // ------------------------------------------------------------
  // Trim is passed as a signed two's complement code to the analog trim
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      current_range_sel_o <= 2'h0;
      current_trim_o      <= 6'h00;
      discharge_o         <= 1'b0;
      module_on_o         <= 1'b0;
      delay_route_o       <= 1'b0;
    end else begin
      current_range_sel_o <= cur_ctrl_reg[ctu_pkg::RANGE_LSB +: 2];
      current_trim_o      <= cur_ctrl_reg[ctu_pkg::TRIM_LSB +: 6];
      discharge_o         <= edge_high_reg[ctu_pkg::DISCH_BIT];
      module_on_o         <= module_enable;
      delay_route_o       <= edge_high_reg[ctu_pkg::MODE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  logic rd_low;
  assign rd_low = rd_i && (addr_i == ctu_pkg::ADDR_EDGE_LOW);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        ctu_pkg::ADDR_CUR_CTRL:  rdata_o <= cur_ctrl_reg;
        ctu_pkg::ADDR_EDGE_LOW:  rdata_o <= edge_low_reg;
        ctu_pkg::ADDR_EDGE_HIGH: rdata_o <= edge_high_reg;
        ctu_pkg::ADDR_FLAGS3:    rdata_o <= {4'h0, flag_reg, 3'h0};
        ctu_pkg::ADDR_ENABLES3:  rdata_o <= {4'h0, irq_en_reg, 3'h0};
        default:                 rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_source_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    source_on_o == $past(src_on))
    else $error("source gate mismatch");

  chk_flag_on_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(source_on_o) |-> flag_reg)
    else $error("flag not set after source off");

  chk_irq_gating: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    irq_o |-> $past(flag_reg) && $past(irq_en_reg))
    else $error("irq without flag and enable");

  chk_edge_block: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!edges_open && !wr_low && !edge_low_reg[1]) |=> !edge_low_reg[1])
    else $error("status set while edges blocked");

  chk_seq_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (sequence_enable && !edge_low_reg[0] && !edge_low_reg[1] && !wr_low)
      |=> !edge_low_reg[1])
    else $error("channel 2 before channel 1");

  chk_level_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    chan1_hit |=> edge_low_reg[0])
    else $error("channel 1 level not captured");

  chk_sw_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_low && !chan1_hit) |=> edge_low_reg[0] == $past(wdata_i[0]))
    else $error("status write lost");

  chk_discharge_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    discharge_o == $past(edge_high_reg[1]))
    else $error("discharge not following bit");

  chk_trim_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    current_trim_o == $past(cur_ctrl_reg[7:2]))
    else $error("trim mismatch");

  // ------------------------------------------------------------
  // Checks on control outputs and status read
  // ------------------------------------------------------------
  chk_range_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    current_range_sel_o == $past(cur_ctrl_reg[1:0]))
    else $error("range mismatch");

  chk_route_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    delay_route_o == $past(edge_high_reg[4]))
    else $error("delay route not following mode bit");

  chk_module_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    module_on_o == $past(module_enable))
    else $error("module enable not following bit");

  // Software finds the last edge from this read
  chk_status_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $past(rd_low) |-> rdata_o == $past(edge_low_reg))
    else $error("status read mismatch");

  // ------------------------------------------------------------
  // Checks on filter, status bits, source, flag and interrupt
  // ------------------------------------------------------------
  // Filter stage may only move where stages two and three agreed
  chk_sync_filter: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((level_reg ^ $past(level_reg)) & ($past(sync2_reg) ^ $past(sync3_reg))) == 4'h0)
    else $error("level moved before stages agreed");

  chk_chan2_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    chan2_hit |=> edge_low_reg[1])
    else $error("channel 2 level not captured");

  chk_hw_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_low && chan2_hit) |=> edge_low_reg[1])
    else $error("software clear beat hardware set");

  chk_status_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (edge_low_reg[0] && !wr_low) |=> edge_low_reg[0])
    else $error("status bit dropped without write");

  chk_block_chan1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!edges_open && !wr_low && !edge_low_reg[0]) |=> !edge_low_reg[0])
    else $error("channel 1 set while edges blocked");

  chk_both_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (edge_low_reg[0] == edge_low_reg[1]) |=> !source_on_o)
    else $error("source on with equal status bits");

  // Only a source turn-off or a software write may raise it
  chk_flag_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(flag_reg) |-> ($fell(source_on_o) || $past(wr_flag)))
    else $error("flag raised without cause");

  chk_flag_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (flag_reg && !wr_flag) |=> flag_reg)
    else $error("flag dropped without write");

  chk_irq_raise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (flag_reg && irq_en_reg) |=> irq_o)
    else $error("irq missing with flag and enable");

  chk_irq_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !flag_reg |=> !irq_o)
    else $error("irq without flag");

endmodule : ctu_edge_ctrl

`default_nettype wire

// ### hdl/ctu_pkg.sv
`default_nettype none
package ctu_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CUR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_EDGE_LOW   = 4'h1;
  localparam logic [3:0] ADDR_EDGE_HIGH  = 4'h2;
  localparam logic [3:0] ADDR_FLAGS3     = 4'h3;
  localparam logic [3:0] ADDR_ENABLES3   = 4'h4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RANGE_LSB    = 0;
  localparam int TRIM_LSB     = 2;
  localparam int STAT1_BIT    = 0;
  localparam int STAT2_BIT    = 1;
  localparam int SRC1_LSB     = 2;
  localparam int POL1_BIT     = 4;
  localparam int SRC2_LSB     = 5;
  localparam int POL2_BIT     = 7;
  localparam int DISCH_BIT    = 1;
  localparam int SEQ_BIT      = 2;
  localparam int EDGE_INPUTS_ENABLE_BIT    = 3;
  localparam int MODE_BIT     = 4;
  localparam int MODEN_BIT    = 7;
  localparam int IRQ_BIT      = 3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CUR_CTRL  = 8'h00;
  localparam logic [7:0] RST_EDGE_LOW  = 8'h00;
  localparam logic [7:0] RST_EDGE_HIGH = 8'h00;

  // ------------------------------------------------------------
  // Source select codes
  // ------------------------------------------------------------
  localparam logic [1:0] SRC_PIN_ONE = 2'h0;
  localparam logic [1:0] SRC_PIN_TWO = 2'h1;
  localparam logic [1:0] SRC_TIMER   = 2'h2;
  localparam logic [1:0] SRC_COMPARE = 2'h3;

  typedef struct packed {
    logic       pin_one;
    logic       pin_two;
    logic       timer;
    logic       compare;
  } ctu_sources_t;

  typedef struct packed {
    logic [1:0] range;
    logic [5:0] trim;
  } ctu_current_t;

endpackage : ctu_pkg
`default_nettype wire

// ### test/ctu_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Edge source partner
// ------------------------------------------------------------
module ctu_src_model (
  input  wire ctu_pkg::ctu_sources_t lvl_i,
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  output var  ctu_pkg::ctu_sources_t src_o
);
  // Levels held until told otherwise; no pulses, the inputs are level-based
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_o <= '0;
    end else begin
      src_o <= lvl_i;
    end
  end
endmodule : ctu_src_model
`default_nettype wire

// ### test/tb_charge_time_edge_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_charge_time_edge_control;
  logic                  ref_clk_i = 1'b0;
  logic                  rst_i     = 1'b1;
  logic [3:0]            addr_i    = 4'h0;
  logic [7:0]            wdata_i   = 8'h00;
  logic                  wr_i      = 1'b0;
  logic                  rd_i      = 1'b0;
  logic [7:0]            rdata_o;
  logic                  source_on_o;
  logic                  discharge_o;
  logic                  module_on_o;
  logic                  delay_route_o;
  logic                  irq_o;
  logic [1:0]            range_o;
  logic [5:0]            trim_o;
  ctu_pkg::ctu_sources_t lvl = '0;
  ctu_pkg::ctu_sources_t src;
  int                    err_count = 0;
  int                    total_checks = 0;
  logic [7:0]            cc;
  logic [1:0]            c;
  logic [7:0]            corner [4] = '{8'h85, 8'h7d, 8'h01, 8'h00};

  ctu_src_model src_u (.lvl_i(lvl), .ref_clk_i(ref_clk_i), .rst_i(rst_i), .src_o(src));

  ctu_edge_ctrl dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .edge_pin_one_i(src.pin_one),
    .edge_pin_two_i(src.pin_two), .timer_evt_i(src.timer), .compare_evt_i(src.compare),
    .source_on_o(source_on_o), .current_range_sel_o(range_o), .current_trim_o(trim_o),
    .discharge_o(discharge_o), .module_on_o(module_on_o),
    .delay_route_o(delay_route_o), .irq_o(irq_o));

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // Bounded: a source that never settles ends the run
  task automatic wait_src(input logic exp);
    int n;
    n = 0;
    #1;
    while (source_on_o !== exp && n < 40) begin
      tick(1);
      n++;
    end
    check({7'h0, source_on_o}, {7'h0, exp});
    if (source_on_o !== exp) begin
      end_of_test();
    end
  endtask : wait_src

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(24));
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk(ctu_pkg::ADDR_EDGE_LOW, 8'h00);
    rchk(ctu_pkg::ADDR_EDGE_HIGH, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cc = (i < 4) ? corner[i] : 8'($urandom);
      wr(ctu_pkg::ADDR_CUR_CTRL, cc);
      tick(1);
      check({trim_o, range_o}, cc);
      rchk(ctu_pkg::ADDR_CUR_CTRL, cc);
    end
    wr(4'h9, 8'hff);
    rchk(ctu_pkg::ADDR_CUR_CTRL, cc);
    rchk(4'h9, 8'h00);
    $display("test current control done");
    // Edges blocked: only software writes move the status bits
    wr(ctu_pkg::ADDR_EDGE_HIGH, 8'h80);
    wr(ctu_pkg::ADDR_EDGE_LOW, 8'h01);
    #1;
    check({7'h0, source_on_o}, 8'h00);
    tick(1);
    check({7'h0, source_on_o}, 8'h01);
    wr(ctu_pkg::ADDR_EDGE_LOW, 8'h03);
    tick(1);
    check({7'h0, source_on_o}, 8'h00);
    wr(ctu_pkg::ADDR_EDGE_LOW, 8'h00);
    tick(12);
    rchk(ctu_pkg::ADDR_EDGE_LOW, 8'h00);
    rchk(ctu_pkg::ADDR_FLAGS3, 8'h08);
    check({7'h0, irq_o}, 8'h00);
    wr(ctu_pkg::ADDR_ENABLES3, 8'h08);
    tick(1);
    check({7'h0, irq_o}, 8'h01);
    wr(ctu_pkg::ADDR_FLAGS3, 8'h00);
    tick(1);
    check({7'h0, irq_o}, 8'h00);
    wr(ctu_pkg::ADDR_EDGE_HIGH, 8'h92);
    tick(1);
    check({5'h0, module_on_o, delay_route_o, discharge_o}, 8'h07);
    $display("test software gating done");
    // Start-up order: disable, enable, clear status, open edges
    wr(ctu_pkg::ADDR_EDGE_HIGH, 8'h00);
    tick(1);
    check({5'h0, module_on_o, delay_route_o, discharge_o}, 8'h00);
    wr(ctu_pkg::ADDR_EDGE_HIGH, 8'h80);
    wr(ctu_pkg::ADDR_EDGE_LOW, 8'h90);
    wr(ctu_pkg::ADDR_EDGE_HIGH, 8'h88);
    cc = 8'($urandom);
    for (int k = 0; k < 4; k++) begin
      c = 2'(k) + cc[1:0];
      wr(ctu_pkg::ADDR_EDGE_LOW, {1'b1, c, 1'b0, c, 2'b00});
      wait_src(1'b1);
      rchk(ctu_pkg::ADDR_EDGE_LOW, {1'b1, c, 1'b0, c, 2'b01});
      lvl <= ctu_pkg::ctu_sources_t'(4'h8 >> c);
      wait_src(1'b0);
      rchk(ctu_pkg::ADDR_EDGE_LOW, {1'b1, c, 1'b0, c, 2'b11});
      lvl <= '0;
      tick(10);
      // Flip polarity first: a live hit would win over the clear
      wr(ctu_pkg::ADDR_EDGE_LOW, {1'b1, c, 1'b1, c, 2'b11});
      wr(ctu_pkg::ADDR_EDGE_LOW, {1'b1, c, 1'b1, c, 2'b00});
      tick(10);
      rchk(ctu_pkg::ADDR_EDGE_LOW, {1'b1, c, 1'b1, c, 2'b00});
    end
    $display("test edge sources done");
    wr(ctu_pkg::ADDR_EDGE_HIGH, 8'h8c);
    wr(ctu_pkg::ADDR_EDGE_LOW, 8'h30);
    tick(12);
    rchk(ctu_pkg::ADDR_EDGE_LOW, 8'h30);
    lvl <= ctu_pkg::ctu_sources_t'(4'h8);
    tick(12);
    rchk(ctu_pkg::ADDR_EDGE_LOW, 8'h33);
    $display("test sequencing done");
    end_of_test();
  end
endmodule : tb_charge_time_edge_control
`default_nettype wire
